// ---- pkg/ilc_params.svh ----
/*
 * Constants of the I/O line controller: line count, bus address width,
 * register offsets and reset values.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef ILC_PARAMS_SVH
`define ILC_PARAMS_SVH

`define ILC_LINES 32
`define ILC_AW 8

`define ILC_OFS_IRQ_EN 8'h00
`define ILC_OFS_IRQ_DIS 8'h04
`define ILC_OFS_IRQ_MASK 8'h08
`define ILC_OFS_IRQ_STAT 8'h0C
`define ILC_OFS_OD_EN 8'h10
`define ILC_OFS_OD_DIS 8'h14
`define ILC_OFS_OD_STAT 8'h18
`define ILC_OFS_PU_DIS 8'h20
`define ILC_OFS_PU_EN 8'h24
`define ILC_OFS_PU_STAT 8'h28
`define ILC_OFS_FN_A 8'h30
`define ILC_OFS_FN_B 8'h34
`define ILC_OFS_FN_STAT 8'h38
`define ILC_OFS_OW_EN 8'h40
`define ILC_OFS_OW_DIS 8'h44
`define ILC_OFS_OW_STAT 8'h48
`define ILC_OFS_OUT_DATA 8'h50
`define ILC_OFS_DRIVE 8'h54

`define ILC_RST_WORD 32'h0000_0000
`define ILC_RST_MASK 32'h0000_0000
`define ILC_RST_OD 32'h0000_0000
`define ILC_RST_PU_OFF 32'h0000_0000
`define ILC_RST_FN_B 32'h0000_0000
`define ILC_RST_OW 32'h0000_0000
`define ILC_RST_DATA 32'h0000_0000
`define ILC_RST_DRIVE 32'h0000_0000

`endif

// ---- pkg/ilc_pkg.sv ----
/*
 * Types of the I/O line controller: the line word and the register selector.
 * Assumes ilc_params.svh is on the include path.
 */
`include "ilc_params.svh"

package ilc_pkg;

    typedef logic [`ILC_LINES-1:0] ilc_word_t;

    typedef enum logic [4:0] {
        ILC_REG_NONE,
        ILC_REG_IRQ_EN,
        ILC_REG_IRQ_DIS,
        ILC_REG_IRQ_MASK,
        ILC_REG_IRQ_STAT,
        ILC_REG_OD_EN,
        ILC_REG_OD_DIS,
        ILC_REG_OD_STAT,
        ILC_REG_PU_DIS,
        ILC_REG_PU_EN,
        ILC_REG_PU_STAT,
        ILC_REG_FN_A,
        ILC_REG_FN_B,
        ILC_REG_FN_STAT,
        ILC_REG_OW_EN,
        ILC_REG_OW_DIS,
        ILC_REG_OW_STAT,
        ILC_REG_OUT_DATA,
        ILC_REG_DRIVE
    } ilc_reg_e;

endpackage

// ---- hw/ilc_setclr.sv ----
/*
 * One 32-bit state word driven by a set word and a clear word, one bit per
 * I/O line. Assumes set and clear never carry the same bit in one cycle.
 */
`timescale 1ns/1ns
`include "ilc_params.svh"

module ilc_setclr
    import ilc_pkg::*;
#(
    parameter ilc_word_t RESET_VAL = `ILC_RST_WORD
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire ilc_word_t set_bits,
    input wire ilc_word_t clr_bits,
    output ilc_word_t state
);

    genvar i;

    generate
        for (i = 0; i < `ILC_LINES; i = i + 1)
        begin : g_bit
            logic bit_r;
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    bit_r <= RESET_VAL[i];
                end
                else if (set_bits[i])
                begin
                    bit_r <= 1'b1;
                end
                else if (clr_bits[i])
                begin
                    bit_r <= 1'b0;
                end
            end
            // One process per bit, joined here so the word has a single driver
            assign state[i] = bit_r;
        end
    endgenerate

endmodule

// ---- hw/ilc_top.sv ----
/*
 * I/O line controller for 32 lines: change interrupts, open-drain drive,
 * pull-ups, peripheral A/B selection and masked direct output writes,
 * all reached over an APB slave with zero wait states.
 * Assumes pin_in is already synchronous to pclk and that the pad ring
 * resolves pin_out/pin_oe and applies pullup_on and periph_b_sel.
 */
// Operation
// - Writing one to interrupt disable bit turns off that line's change interrupt.
// - Interrupt mask bit reads one when the line's change interrupt is enabled.
// - Status bit sets on any level change since last status read or reset.
// - Reading change status clears it; only later changes read as one.
// - Writing one to open-drain enable bit puts that line in multi-drive.
// - Writing one to open-drain disable bit returns that line to push-pull.
// - Multi-drive lines drive low only and read status one; else zero.
// - Writing one to pull-up disable bit switches that line's pull-up off.
// - Writing one to pull-up enable bit switches that line's pull-up on.
// - Pull-up status reads zero when pull-up active, one when off.
// - Writing one to function-A select bit routes that line to function A.
// - Writing one to function-B select bit routes that line to function B.
// - Function status reads zero for function A, one for function B.
// - Writing one to interrupt enable bit turns on that line's change interrupt.
// - Writing one to output-write enable lets direct data writes reach that line.
// - Writing one to output-write disable blocks direct data writes to that line.
// - Output-write status reads one when direct data writes reach the line.
`timescale 1ns/1ns
`include "ilc_params.svh"

module ilc_top
    import ilc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ILC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ilc_word_t pin_in,
    output ilc_word_t pin_out,
    output ilc_word_t pin_oe,
    output ilc_word_t pullup_on,
    output ilc_word_t periph_b_sel,
    output logic irq
);

    function automatic ilc_reg_e reg_decode(input logic [`ILC_AW-1:0] addr);
        reg_decode = ILC_REG_NONE;
        case (addr)
            `ILC_OFS_IRQ_EN: reg_decode = ILC_REG_IRQ_EN;
            `ILC_OFS_IRQ_DIS: reg_decode = ILC_REG_IRQ_DIS;
            `ILC_OFS_IRQ_MASK: reg_decode = ILC_REG_IRQ_MASK;
            `ILC_OFS_IRQ_STAT: reg_decode = ILC_REG_IRQ_STAT;
            `ILC_OFS_OD_EN: reg_decode = ILC_REG_OD_EN;
            `ILC_OFS_OD_DIS: reg_decode = ILC_REG_OD_DIS;
            `ILC_OFS_OD_STAT: reg_decode = ILC_REG_OD_STAT;
            `ILC_OFS_PU_DIS: reg_decode = ILC_REG_PU_DIS;
            `ILC_OFS_PU_EN: reg_decode = ILC_REG_PU_EN;
            `ILC_OFS_PU_STAT: reg_decode = ILC_REG_PU_STAT;
            `ILC_OFS_FN_A: reg_decode = ILC_REG_FN_A;
            `ILC_OFS_FN_B: reg_decode = ILC_REG_FN_B;
            `ILC_OFS_FN_STAT: reg_decode = ILC_REG_FN_STAT;
            `ILC_OFS_OW_EN: reg_decode = ILC_REG_OW_EN;
            `ILC_OFS_OW_DIS: reg_decode = ILC_REG_OW_DIS;
            `ILC_OFS_OW_STAT: reg_decode = ILC_REG_OW_STAT;
            `ILC_OFS_OUT_DATA: reg_decode = ILC_REG_OUT_DATA;
            `ILC_OFS_DRIVE: reg_decode = ILC_REG_DRIVE;
            default: reg_decode = ILC_REG_NONE;
        endcase
    endfunction

    // Strobe word for a write to one register, zero otherwise
    function automatic ilc_word_t wr_word(input logic hit, input logic [31:0] data);
        wr_word = hit ? data : `ILC_RST_WORD;
    endfunction

    ilc_reg_e sel;
    logic setup;
    logic access;
    logic wr_access;
    logic rd_access;

    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] rdata_nxt;
    logic err_nxt;

    ilc_word_t irq_mask;
    ilc_word_t od_state;
    ilc_word_t pu_off;
    ilc_word_t fn_b;
    ilc_word_t ow_state;

    ilc_word_t irq_stat_r;
    ilc_word_t irq_stat_nxt;
    ilc_word_t pin_prev_r;
    logic armed_r;
    ilc_word_t change;
    ilc_word_t stat_clr;

    ilc_word_t out_data_r;
    ilc_word_t drive_r;
    ilc_word_t pin_out_r;
    ilc_word_t pin_oe_r;
    ilc_word_t pullup_on_r;
    ilc_word_t periph_b_r;
    logic irq_r;

    assign sel = reg_decode(paddr);
    assign setup = psel && !penable;
    assign access = psel && penable && pready_r;
    assign wr_access = access && pwrite;
    assign rd_access = access && !pwrite;

    // Read data and error are prepared in the setup cycle so that the
    // answer comes from flip-flops with no wait state.
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        err_nxt = 1'b0;
        unique case (sel)
            ILC_REG_IRQ_MASK: rdata_nxt = irq_mask;
            ILC_REG_IRQ_STAT: rdata_nxt = irq_stat_r;
            ILC_REG_OD_STAT: rdata_nxt = od_state;
            ILC_REG_PU_STAT: rdata_nxt = pu_off;
            ILC_REG_FN_STAT: rdata_nxt = fn_b;
            ILC_REG_OW_STAT: rdata_nxt = ow_state;
            ILC_REG_OUT_DATA: rdata_nxt = out_data_r;
            ILC_REG_DRIVE: rdata_nxt = drive_r;
            ILC_REG_NONE: err_nxt = 1'b1;
            ILC_REG_IRQ_EN,
            ILC_REG_IRQ_DIS,
            ILC_REG_OD_EN,
            ILC_REG_OD_DIS,
            ILC_REG_PU_DIS,
            ILC_REG_PU_EN,
            ILC_REG_FN_A,
            ILC_REG_FN_B,
            ILC_REG_OW_EN,
            ILC_REG_OW_DIS: rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
        end
        else
        begin
            pready_r <= setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else if (setup)
        begin
            prdata_r <= pwrite ? 32'h0000_0000 : rdata_nxt;
            pslverr_r <= err_nxt;
        end
        else if (access)
        begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
    end

    // Set/clear state words; a write touches only the bits written as one
    ilc_setclr #(
        .RESET_VAL(`ILC_RST_MASK)
    ) u_irq_mask (
        .pclk(pclk),
        .presetn(presetn),
        .set_bits(wr_word(wr_access && sel == ILC_REG_IRQ_EN, pwdata)),
        .clr_bits(wr_word(wr_access && sel == ILC_REG_IRQ_DIS, pwdata)),
        .state(irq_mask)
    );

    ilc_setclr #(
        .RESET_VAL(`ILC_RST_OD)
    ) u_open_drain (
        .pclk(pclk),
        .presetn(presetn),
        .set_bits(wr_word(wr_access && sel == ILC_REG_OD_EN, pwdata)),
        .clr_bits(wr_word(wr_access && sel == ILC_REG_OD_DIS, pwdata)),
        .state(od_state)
    );

    // Held in the inverted sense so it reads back directly as status
    ilc_setclr #(
        .RESET_VAL(`ILC_RST_PU_OFF)
    ) u_pullup_off (
        .pclk(pclk),
        .presetn(presetn),
        .set_bits(wr_word(wr_access && sel == ILC_REG_PU_DIS, pwdata)),
        .clr_bits(wr_word(wr_access && sel == ILC_REG_PU_EN, pwdata)),
        .state(pu_off)
    );

    ilc_setclr #(
        .RESET_VAL(`ILC_RST_FN_B)
    ) u_function_b (
        .pclk(pclk),
        .presetn(presetn),
        .set_bits(wr_word(wr_access && sel == ILC_REG_FN_B, pwdata)),
        .clr_bits(wr_word(wr_access && sel == ILC_REG_FN_A, pwdata)),
        .state(fn_b)
    );

    ilc_setclr #(
        .RESET_VAL(`ILC_RST_OW)
    ) u_output_write (
        .pclk(pclk),
        .presetn(presetn),
        .set_bits(wr_word(wr_access && sel == ILC_REG_OW_EN, pwdata)),
        .clr_bits(wr_word(wr_access && sel == ILC_REG_OW_DIS, pwdata)),
        .state(ow_state)
    );

    // Only lines enabled for output writes take the new data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_data_r <= `ILC_RST_DATA;
        end
        else if (wr_access && sel == ILC_REG_OUT_DATA)
        begin
            out_data_r <= (out_data_r & ~ow_state) | (pwdata & ow_state);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            drive_r <= `ILC_RST_DRIVE;
        end
        else if (wr_access && sel == ILC_REG_DRIVE)
        begin
            drive_r <= pwdata;
        end
    end

    // The first sample after reset only primes the history, so a pin that
    // idles high does not raise a false change.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_prev_r <= `ILC_RST_WORD;
            armed_r <= 1'b0;
        end
        else
        begin
            pin_prev_r <= pin_in;
            armed_r <= 1'b1;
        end
    end

    assign change = armed_r ? (pin_in ^ pin_prev_r) : `ILC_RST_WORD;

    // A read clears only what it returned, so a change that lands between
    // the setup and access cycles survives for the next read.
    always_comb
    begin
        stat_clr = `ILC_RST_WORD;
        if (rd_access && sel == ILC_REG_IRQ_STAT)
        begin
            stat_clr = prdata_r;
        end
        else if (wr_access && sel == ILC_REG_IRQ_STAT)
        begin
            stat_clr = pwdata;
        end
    end

    // Set wins over clear in the same cycle
    assign irq_stat_nxt = (irq_stat_r & ~stat_clr) | change;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_stat_r <= `ILC_RST_WORD;
        end
        else
        begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_r <= 1'b0;
        end
        else
        begin
            irq_r <= |(irq_stat_r & irq_mask);
        end
    end

    // Open-drain lines never drive high: a one releases the pad instead
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out_r <= `ILC_RST_WORD;
            pin_oe_r <= `ILC_RST_WORD;
        end
        else
        begin
            pin_out_r <= out_data_r & ~od_state;
            pin_oe_r <= drive_r & ~(od_state & out_data_r);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pullup_on_r <= ~`ILC_RST_PU_OFF;
            periph_b_r <= `ILC_RST_FN_B;
        end
        else
        begin
            pullup_on_r <= ~pu_off;
            periph_b_r <= fn_b;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pin_out = pin_out_r;
    assign pin_oe = pin_oe_r;
    assign pullup_on = pullup_on_r;
    assign periph_b_sel = periph_b_r;
    assign irq = irq_r;

endmodule

// ---- verification/ilc_top_assertions.sv ----
/*
 * Checker for the I/O line controller: APB answer timing and register
 * views against the pin-side outputs.
 * Assumes zero-wait APB answers and a bind onto ilc_top.
 */
`timescale 1ns/1ns
`include "ilc_params.svh"

module ilc_chk
    import ilc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ILC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire ilc_word_t pin_out,
    input wire ilc_word_t pullup_on,
    input wire ilc_word_t periph_b_sel,
    input wire logic irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic rd_acc;
    logic wr_acc;
    assign rd_acc = psel && penable && pready && !pwrite;
    assign wr_acc = psel && penable && pready && pwrite;

    ready_timing_a: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    pready_once_a: assert property (pready |=> !pready)
        else $error("pready held past access");
    wo_read_a: assert property (rd_acc && paddr inside {8'h00, 8'h04, 8'h10, 8'h14,
        8'h20, 8'h24, 8'h30, 8'h34, 8'h40, 8'h44} |-> prdata == 32'h0000_0000)
        else $error("write-only register read nonzero");
    fn_stat_a: assert property (rd_acc && paddr == 8'h38 |-> prdata == periph_b_sel)
        else $error("function status differs from select");
    pu_stat_a: assert property (rd_acc && paddr == 8'h28 |-> prdata == ~pullup_on)
        else $error("pull-up status not inverse of pull-up");
    od_low_a: assert property (rd_acc && paddr == 8'h18 |-> (prdata & pin_out) == 0)
        else $error("multi-drive line driven high");
    mask_irq_a: assert property (rd_acc && paddr == 8'h08 && prdata == 0 |=> !irq)
        else $error("irq with empty mask");
    fnb_write_a: assert property (wr_acc && paddr == 8'h34 |->
        ##2 (periph_b_sel & $past(pwdata, 2)) == $past(pwdata, 2))
        else $error("function B select not applied");
    fna_write_a: assert property (wr_acc && paddr == 8'h30 |->
        ##2 (periph_b_sel & $past(pwdata, 2)) == 0)
        else $error("function A select not applied");
    pu_off_a: assert property (wr_acc && paddr == 8'h20 |->
        ##2 (pullup_on & $past(pwdata, 2)) == 0)
        else $error("pull-up disable not applied");

    cover property (psel && penable && pready && pslverr);
    cover property ($rose(irq));
    cover property (rd_acc && paddr == 8'h0C && prdata != 0);
endmodule

bind ilc_top ilc_chk i_ilc_chk(.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_out(pin_out), .pullup_on(pullup_on),
    .periph_b_sel(periph_b_sel), .irq(irq));

// ---- verification/ilc_pad_model.sv ----
/*
 * Pad ring model: resolves each line from controller drive, an outside
 * driver, the pull-up, or a floating level that flips every cycle.
 * Assumes the bench never drives a line the controller also drives.
 */
`timescale 1ns/1ns

module ilc_pad_model
    import ilc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire ilc_word_t pin_out,
    input wire ilc_word_t pin_oe,
    input wire ilc_word_t pullup_on,
    input wire ilc_word_t ext_oe,
    input wire ilc_word_t ext_val,
    output ilc_word_t pin_in
);
    ilc_word_t lvl;
    // Registered so pin_in is synchronous; floating lines flip to expose stale reads
    assign lvl = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
        | (~pin_oe & ~ext_oe & pullup_on)
        | (~pin_oe & ~ext_oe & ~pullup_on & ~pin_in);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_in <= 32'hFFFF_FFFF;
        else
            pin_in <= lvl;
    end
endmodule

// ---- verification/ilc_top_tb_top.sv ----
/*
 * Bench for the I/O line controller: APB register sequences with
 * expected values, pins resolved by the pad model.
 * Assumes ilc_params.svh on the include path and the checker bound in.
 */
`timescale 1ns/1ns
`include "ilc_params.svh"

module ilc_top_tb_top
    import ilc_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [`ILC_AW-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic irq;
    logic err;
    ilc_word_t pin_in;
    ilc_word_t pin_out;
    ilc_word_t pin_oe;
    ilc_word_t pullup_on;
    ilc_word_t periph_b_sel;
    ilc_word_t ext_oe = 32'h0000_0000;
    ilc_word_t ext_val = 32'h0000_0000;
    logic [7:0] wo [10] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h20, 8'h24, 8'h30, 8'h34,
        8'h40, 8'h44};
    int err_total = 0;
    int n_compared = 0;

    initial
    begin
        forever #20 pclk = ~pclk;
    end

    ilc_top i_ilc_top(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pullup_on(pullup_on), .periph_b_sel(periph_b_sel), .irq(irq));
    ilc_pad_model i_ilc_pad_model(.pclk(pclk), .presetn(presetn), .pin_out(pin_out),
        .pin_oe(pin_oe), .pullup_on(pullup_on), .ext_oe(ext_oe), .ext_val(ext_val),
        .pin_in(pin_in));

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic xfer(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= is_wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait on pready itself; only the watchdog ends a wait that never completes
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(what, exp, rd);
    endtask

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("pullup_on", 32'hFFFF_FFFF, pullup_on);
        rdchk("mask", 8'h08, 32'h0000_0000);
        rdchk("od_stat", 8'h18, 32'h0000_0000);
        rdchk("pu_stat", 8'h28, 32'h0000_0000);
        rdchk("fn_stat", 8'h38, 32'h0000_0000);
        rdchk("ow_stat", 8'h48, 32'h0000_0000);
        foreach (wo[i]) rdchk("wo_read", wo[i], 32'h0000_0000);
        xfer(1'b0, 8'h5C, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, {31'h0, err});
        $display("test reset and map done");
        wr(8'h00, 32'hA5A5_0F0F);
        wr(8'h04, 32'h0000_0F00);
        rdchk("mask", 8'h08, 32'hA5A5_000F);
        rdchk("status", 8'h0C, 32'h0000_0000);
        ext_oe <= 32'h0000_0018;
        repeat (4) @(posedge pclk);
        chk("irq", 32'h0000_0001, {31'h0, irq});
        rdchk("status", 8'h0C, 32'h0000_0018);
        rdchk("status", 8'h0C, 32'h0000_0000);
        chk("irq", 32'h0000_0000, {31'h0, irq});
        ext_oe <= 32'h0000_0000;
        repeat (4) @(posedge pclk);
        rdchk("status", 8'h0C, 32'h0000_0018);
        wr(8'h04, 32'hFFFF_FFFF);
        rdchk("mask", 8'h08, 32'h0000_0000);
        $display("test change interrupt done");
        wr(8'h10, 32'hFFFF_0000);
        wr(8'h14, 32'h0F00_0000);
        rdchk("od_stat", 8'h18, 32'hF0FF_0000);
        wr(8'h40, 32'h00FF_00FF);
        wr(8'h44, 32'h0000_000F);
        rdchk("ow_stat", 8'h48, 32'h00FF_00F0);
        wr(8'h54, 32'hFFFF_FFFF);
        wr(8'h50, 32'hFFFF_FFFF);
        rdchk("out_data", 8'h50, 32'h00FF_00F0);
        chk("pin_out", 32'h0000_00F0, pin_out);
        chk("pin_oe", 32'hFF00_FFFF, pin_oe);
        $display("test drive done");
        wr(8'h20, 32'h0000_FFFF);
        wr(8'h24, 32'h0000_00FF);
        rdchk("pu_stat", 8'h28, 32'h0000_FF00);
        chk("pullup_on", 32'hFFFF_00FF, pullup_on);
        $display("test pull-up done");
        wr(8'h34, 32'hFF00_FF00);
        wr(8'h30, 32'h0F00_0000);
        rdchk("fn_stat", 8'h38, 32'hF000_FF00);
        chk("periph_b_sel", 32'hF000_FF00, periph_b_sel);
        $display("test function select done");
        summarize();
    end

    initial
    begin
        #400000;
        err_total++;
        summarize();
    end
endmodule
